// file: rtl/irq_link_pkg.sv
/*
 * package for the interrupt enable and link flag block: register indices,
 * field positions, reset values and bus response codes.
 * assumes byte address = 4 * register index on a 32-bit AXI4-Lite bus.
 */
package irq_link_pkg;

    // ************************************************************
    // register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [9:0] IDX_GROUP0_IRQ_FLAGS    = 10'h063;
    localparam logic [9:0] IDX_GROUP0_IRQ_ENABLES  = 10'h064;
    localparam logic [9:0] IDX_GROUP1_IRQ_MASK     = 10'h065;
    localparam logic [9:0] IDX_GROUP1_IRQ_FLAGS    = 10'h07F;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_GROUP0_IRQ_ENABLES  = 8'h00;
    localparam logic [7:0] RST_GROUP0_IRQ_FLAGS    = 8'h00;
    localparam logic [7:0] RST_GROUP1_IRQ_FLAGS    = 8'h00;
    localparam logic [7:0] RST_GROUP1_IRQ_MASK     = 8'h00;

    // ************************************************************
    // group 0 field positions
    // ************************************************************
    localparam int BIT_END_OF_PACKET    = 7;
    localparam int BIT_RX_FIFO_EMPTY    = 6;
    localparam int BIT_SELF_INIT        = 5;
    localparam int BIT_OSC_INIT         = 4;
    localparam int BIT_FLASH_OP         = 3;
    localparam int BIT_TX_DONE          = 2;
    localparam int BIT_RX_FIFO_FULL     = 1;
    localparam int BIT_PACKET_RX        = 0;

    // ************************************************************
    // group 1 field positions and implemented bits
    // ************************************************************
    localparam int BIT_WAKE_ON_LAN      = 5;
    localparam int BIT_LINK_CHANGE      = 4;
    localparam int BIT_JABBER           = 3;
    localparam int BIT_AUTONEG_FAIL     = 2;
    localparam int BIT_AUTONEG_DONE     = 0;
    localparam logic [7:0] GROUP1_IMPL_MASK = 8'h3D;

    // ************************************************************
    // bus response codes
    // ************************************************************
    localparam logic [1:0] RESP_OKAY    = 2'b00;
    localparam logic [1:0] RESP_SLVERR  = 2'b10;

    typedef enum logic [1:0] {
        WR_IDLE      = 2'b00,
        WR_HAVE_ADDR = 2'b01,
        WR_HAVE_DATA = 2'b10,
        WR_RESP      = 2'b11
    } wr_state_e;

    typedef enum logic {
        RD_IDLE = 1'b0,
        RD_RESP = 1'b1
    } rd_state_e;

endpackage

// file: rtl/irq_link_flags.sv
/*
 * interrupt enable register, group 0 and group 1 sticky flag registers,
 * and the interrupt request output, reached over an AXI4-Lite slave.
 * assumes event inputs are synchronous to mclk_i; event pulses are one
 * cycle per event, link_up_i is a level.
 */
// The implementer's own choice: the AXI4-Lite register port.
// Summary of operation
// - eight-bit enable register, reset zero, one enables
// - reading group1 flags returns them, then clears
// - group1 bits 7, 6 and 1 read zero
// - bit 5 sets on network connect, sticky
// - bit 4 sets on any link change, sticky
// - bit 3 sets on jabber detect, sticky
// - bit 2 sets on autoneg failure, sticky
// - bit 0 sets on autoneg done; reset zero
`timescale 1ns/1ps

module irq_link_flags
    import irq_link_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic [2:0]        s_axi_awprot_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    // axi4-lite write data
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic [2:0]        s_axi_arprot_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    // axi4-lite read data
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    // event sources
    input  wire logic [7:0]        group0_events_i,
    input  wire logic              link_up_i,
    input  wire logic              jabber_detect_i,
    input  wire logic              autoneg_fail_i,
    input  wire logic              autoneg_done_i,
    // interrupt request
    output logic                   irq_o
);

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic idx_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [9:0]        idx);
        logic [9:0] word;
        word = 10'(addr[ADDR_W-1:2]);
        return word == idx;
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        return idx_hit(addr, IDX_GROUP0_IRQ_FLAGS)
            || idx_hit(addr, IDX_GROUP0_IRQ_ENABLES)
            || idx_hit(addr, IDX_GROUP1_IRQ_MASK)
            || idx_hit(addr, IDX_GROUP1_IRQ_FLAGS);
    endfunction

    function automatic logic [31:0] byte_word(input logic [7:0] b);
        return {24'h00_0000, b};
    endfunction

    // set wins over a clearing read in the same cycle
    function automatic logic [7:0] sticky_next(input logic [7:0] flags,
                                                input logic       clr,
                                                input logic [7:0] set);
        return (flags & {8{~clr}}) | set;
    endfunction

    // ************************************************************
    // declarations
    // ************************************************************
    wr_state_e         wr_state_r;
    wr_state_e         wr_state_nxt;
    rd_state_e         rd_state_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic [1:0]        bresp_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;
    logic [7:0]        group0_irq_enables_r;
    logic [7:0]        group0_irq_flags_r;
    logic [7:0]        group1_irq_flags_r;
    logic [7:0]        group1_irq_mask_r;
    logic              link_up_prev_r;
    logic              irq_r;

    logic              aw_hs;
    logic              w_hs;
    logic              ar_hs;
    logic              wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0]       wr_data;
    logic [3:0]        wr_strb;
    logic              g0_rd_clr;
    logic              g1_rd_clr;
    logic [7:0]        group1_set;
    logic              link_rise;
    logic              link_change;
    logic              g0_pending;
    logic              g1_pending;

    // ************************************************************
    // write channel handshakes
    // ************************************************************
    assign s_axi_awready_o = (wr_state_r == WR_IDLE) || (wr_state_r == WR_HAVE_DATA);
    assign s_axi_wready_o  = (wr_state_r == WR_IDLE) || (wr_state_r == WR_HAVE_ADDR);
    assign s_axi_bvalid_o  = (wr_state_r == WR_RESP);
    assign s_axi_bresp_o   = bresp_r;

    assign aw_hs   = s_axi_awvalid_i && s_axi_awready_o;
    assign w_hs    = s_axi_wvalid_i && s_axi_wready_o;
    assign wr_addr = aw_hs ? s_axi_awaddr_i : awaddr_r;
    assign wr_data = w_hs ? s_axi_wdata_i : wdata_r;
    assign wr_strb = w_hs ? s_axi_wstrb_i : wstrb_r;

    always_comb begin
        wr_state_nxt = wr_state_r;
        case (wr_state_r)
            WR_IDLE: begin
                if (aw_hs && w_hs) begin
                    wr_state_nxt = WR_RESP;
                end else if (aw_hs) begin
                    wr_state_nxt = WR_HAVE_ADDR;
                end else if (w_hs) begin
                    wr_state_nxt = WR_HAVE_DATA;
                end
            end
            WR_HAVE_ADDR: begin
                if (w_hs) begin
                    wr_state_nxt = WR_RESP;
                end
            end
            WR_HAVE_DATA: begin
                if (aw_hs) begin
                    wr_state_nxt = WR_RESP;
                end
            end
            WR_RESP: begin
                if (s_axi_bready_i) begin
                    wr_state_nxt = WR_IDLE;
                end
            end
            default: begin
                wr_state_nxt = WR_IDLE;
            end
        endcase
    end

    // register update happens at the edge both halves are held
    assign wr_fire = (wr_state_r != WR_RESP) && (wr_state_nxt == WR_RESP);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            wr_state_r <= WR_IDLE;
        end else begin
            wr_state_r <= wr_state_nxt;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            awaddr_r <= '0;
            wdata_r  <= 32'h0000_0000;
            wstrb_r  <= 4'h0;
        end else begin
            if (aw_hs) begin
                awaddr_r <= s_axi_awaddr_i;
            end
            if (w_hs) begin
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            bresp_r <= RESP_OKAY;
        end else if (wr_fire) begin
            bresp_r <= addr_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    assign s_axi_arready_o = (rd_state_r == RD_IDLE);
    assign s_axi_rvalid_o  = (rd_state_r == RD_RESP);
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;
    assign ar_hs           = s_axi_arvalid_i && s_axi_arready_o;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rd_state_r <= RD_IDLE;
        end else begin
            case (rd_state_r)
                RD_IDLE: begin
                    if (ar_hs) begin
                        rd_state_r <= RD_RESP;
                    end
                end
                RD_RESP: begin
                    if (s_axi_rready_i) begin
                        rd_state_r <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_r <= RD_IDLE;
                end
            endcase
        end
    end

    // read data captured at the address edge, before any clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_r <= 32'h0000_0000;
            rresp_r <= RESP_OKAY;
        end else if (ar_hs) begin
            rresp_r <= RESP_OKAY;
            if (idx_hit(s_axi_araddr_i, IDX_GROUP0_IRQ_FLAGS)) begin
                rdata_r <= byte_word(group0_irq_flags_r);
            end else if (idx_hit(s_axi_araddr_i, IDX_GROUP0_IRQ_ENABLES)) begin
                rdata_r <= byte_word(group0_irq_enables_r);
            end else if (idx_hit(s_axi_araddr_i, IDX_GROUP1_IRQ_MASK)) begin
                rdata_r <= byte_word(group1_irq_mask_r);
            end else if (idx_hit(s_axi_araddr_i, IDX_GROUP1_IRQ_FLAGS)) begin
                rdata_r <= byte_word(group1_irq_flags_r & GROUP1_IMPL_MASK);
            end else begin
                rdata_r <= 32'h0000_0000;
                rresp_r <= RESP_SLVERR;
            end
        end
    end

    assign g0_rd_clr = ar_hs && idx_hit(s_axi_araddr_i, IDX_GROUP0_IRQ_FLAGS);
    assign g1_rd_clr = ar_hs && idx_hit(s_axi_araddr_i, IDX_GROUP1_IRQ_FLAGS);

    // ************************************************************
    // writable registers
    // ************************************************************
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            group0_irq_enables_r <= RST_GROUP0_IRQ_ENABLES;
        end else if (wr_fire && wr_strb[0]
                     && idx_hit(wr_addr, IDX_GROUP0_IRQ_ENABLES)) begin
            group0_irq_enables_r <= wr_data[7:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            group1_irq_mask_r <= RST_GROUP1_IRQ_MASK;
        end else if (wr_fire && wr_strb[0]
                     && idx_hit(wr_addr, IDX_GROUP1_IRQ_MASK)) begin
            group1_irq_mask_r <= wr_data[7:0] & GROUP1_IMPL_MASK;
        end
    end

    // ************************************************************
    // group 0 sticky flags
    // ************************************************************
    // recorded whatever the enables say; set wins over read clear
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            group0_irq_flags_r <= RST_GROUP0_IRQ_FLAGS;
        end else begin
            group0_irq_flags_r <= sticky_next(group0_irq_flags_r, g0_rd_clr,
                                              group0_events_i);
        end
    end

    // ************************************************************
    // group 1 link event detection
    // ************************************************************
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            link_up_prev_r <= 1'b0;
        end else begin
            link_up_prev_r <= link_up_i;
        end
    end

    assign link_rise   = link_up_i && !link_up_prev_r;
    assign link_change = link_up_i != link_up_prev_r;

    always_comb begin
        group1_set                   = 8'h00;
        group1_set[BIT_WAKE_ON_LAN]  = link_rise;
        group1_set[BIT_LINK_CHANGE]  = link_change;
        group1_set[BIT_JABBER]       = jabber_detect_i;
        group1_set[BIT_AUTONEG_FAIL] = autoneg_fail_i;
        group1_set[BIT_AUTONEG_DONE] = autoneg_done_i;
    end

    // ************************************************************
    // group 1 sticky flags
    // ************************************************************
    // set wins over read clear; unused bits never set
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            group1_irq_flags_r <= RST_GROUP1_IRQ_FLAGS;
        end else begin
            group1_irq_flags_r <= sticky_next(group1_irq_flags_r, g1_rd_clr,
                                              group1_set) & GROUP1_IMPL_MASK;
        end
    end

    // ************************************************************
    // interrupt request
    // ************************************************************
    assign g0_pending = |(group0_irq_flags_r & group0_irq_enables_r);
    assign g1_pending = |(group1_irq_flags_r & group1_irq_mask_r);

    // registered: one more cycle of latency, no glitches on the pin
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= g0_pending || g1_pending;
        end
    end

    assign irq_o = irq_r;

endmodule

// file: sim/irq_link_flags_checker.sv
/* checker: bus answers and group 1 flag reads of irq_link_flags.
   assumes it is bound to the top module; one clock, sync reset. */
`timescale 1ns/1ps
module irq_link_flags_checker
    import irq_link_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic              mclk_i,
    input wire logic              srst_i,
    input wire logic              s_axi_awvalid_i,
    input wire logic              s_axi_awready_o,
    input wire logic              s_axi_wvalid_i,
    input wire logic              s_axi_wready_o,
    input wire logic              s_axi_bvalid_o,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic              s_axi_arvalid_i,
    input wire logic              s_axi_arready_o,
    input wire logic [31:0]       s_axi_rdata_o,
    input wire logic              s_axi_rvalid_o,
    input wire logic              link_up_i,
    input wire logic              jabber_detect_i,
    input wire logic              autoneg_fail_i,
    input wire logic              autoneg_done_i
);
    // ************************************************************
    // helper copy of the group 1 flags
    // ************************************************************
    logic [7:0] g1_r;
    logic       link_prev_r;
    logic [7:0] g1_set;
    logic       ar_g1;
    assign ar_g1 = s_axi_arvalid_i && s_axi_arready_o
                   && (10'(s_axi_araddr_i[ADDR_W-1:2]) == IDX_GROUP1_IRQ_FLAGS);
    assign g1_set = {2'b00, link_up_i && !link_prev_r, link_up_i != link_prev_r,
                     jabber_detect_i, autoneg_fail_i, 1'b0, autoneg_done_i};
    always_ff @(posedge mclk_i) begin
        if (srst_i) link_prev_r <= 1'b0;
        else link_prev_r <= link_up_i;
    end
    always_ff @(posedge mclk_i) begin
        if (srst_i) g1_r <= 8'h00;
        else if (ar_g1) g1_r <= g1_set;
        else g1_r <= g1_r | g1_set;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    sequence g1_read;
        ar_g1;
    endsequence
    sequence wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    a_wake_flag: assert property (g1_read |=> s_axi_rdata_o[5] == $past(g1_r[5]))
        else $error("wake flag read wrong");
    a_link_flag: assert property (g1_read |=> s_axi_rdata_o[4] == $past(g1_r[4]))
        else $error("link change flag read wrong");
    a_jabber_flag: assert property (g1_read |=> s_axi_rdata_o[3] == $past(g1_r[3]))
        else $error("jabber flag read wrong");
    a_fail_flag: assert property (g1_read |=> s_axi_rdata_o[2] == $past(g1_r[2]))
        else $error("autoneg fail flag read wrong");
    a_done_flag: assert property (g1_read |=> s_axi_rdata_o[0] == $past(g1_r[0]))
        else $error("autoneg done flag read wrong");
    a_unused_zero: assert property (g1_read ##1 1'b1 |-> s_axi_rdata_o[7:6] == 2'b00
        && !s_axi_rdata_o[1]) else $error("unused group 1 bits not zero");
    a_upper_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h00_0000)
        else $error("read data upper bits not zero");
    a_write_answer: assert property (wr_taken |=> s_axi_bvalid_o)
        else $error("write response late");
    sequence rd_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    a_read_refused: assert property (rd_taken |=> s_axi_rvalid_o && !s_axi_arready_o)
        else $error("read not answered or not refused");
endmodule
bind irq_link_flags irq_link_flags_checker #(.ADDR_W(ADDR_W)) i_irq_link_flags_checker (
    .mclk_i(mclk_i), .srst_i(srst_i), .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_araddr_i(s_axi_araddr_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rdata_o(s_axi_rdata_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .link_up_i(link_up_i),
    .jabber_detect_i(jabber_detect_i), .autoneg_fail_i(autoneg_fail_i),
    .autoneg_done_i(autoneg_done_i));

// file: sim/axi_host_model.sv
/* host processor model: an axi4-lite master with one write and one
   read task. assumes the slave answers on its own handshakes. */
`timescale 1ns/1ps
module axi_host_model (
    input  wire logic        mclk_i,
    output logic [11:0]      awaddr_o,
    output logic             awvalid_o,
    input  wire logic        awready_i,
    output logic [31:0]      wdata_o,
    output logic             wvalid_o,
    input  wire logic        wready_i,
    input  wire logic        bvalid_i,
    output logic             bready_o,
    output logic [11:0]      araddr_o,
    output logic             arvalid_o,
    input  wire logic        arready_i,
    input  wire logic        rvalid_i,
    output logic             rready_o
);
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o} = '0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bit aw_ok;
        bit w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge mclk_i);
        awaddr_o <= a;
        awvalid_o <= 1'b1;
        wdata_o <= d;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge mclk_i);
            if (!aw_ok && awready_i) begin
                aw_ok = 1;
                awvalid_o <= 1'b0;
            end
            if (!w_ok && wready_i) begin
                w_ok = 1;
                wvalid_o <= 1'b0;
            end
        end
        do @(posedge mclk_i); while (!bvalid_i);
        bready_o <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge mclk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        do @(posedge mclk_i); while (!arready_i);
        arvalid_o <= 1'b0;
        do @(posedge mclk_i); while (!rvalid_i);
        rready_o <= 1'b0;
    endtask
endmodule

// file: sim/irq_link_flags_bench.sv
/* self-checking bench for irq_link_flags with the host model.
   assumes a 25 MHz clock and the package register indices. */
`timescale 1ns/1ps
module irq_link_flags_bench;
    import irq_link_pkg::*;
    localparam logic [11:0] A_EN  = {IDX_GROUP0_IRQ_ENABLES, 2'b00};
    localparam logic [11:0] A_G0  = {IDX_GROUP0_IRQ_FLAGS, 2'b00};
    localparam logic [11:0] A_G1  = {IDX_GROUP1_IRQ_FLAGS, 2'b00};
    localparam logic [11:0] A_MK  = {IDX_GROUP1_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_BAD = 12'h004;
    logic        mclk = 0, srst = 1, link_up = 0, jab = 0, fail = 0, done = 0;
    logic [7:0]  g0ev = 8'h00, en, ds;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    logic [33:0] exp_q[$];
    int          err_total = 0, tests_run = 0;
    integer      seed = 32'hb1f3cbcb;
    always #20 mclk = ~mclk;
    irq_link_flags i_irq_link_flags (.mclk_i(mclk), .srst_i(srst),
        .s_axi_awaddr_i(awaddr), .s_axi_awprot_i(3'b000), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
        .s_axi_arprot_i(3'b000), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .group0_events_i(g0ev), .link_up_i(link_up),
        .jabber_detect_i(jab), .autoneg_fail_i(fail), .autoneg_done_i(done), .irq_o(irq));
    axi_host_model i_axi_host_model (.mclk_i(mclk), .awaddr_o(awaddr), .awvalid_o(awvalid),
        .awready_i(awready), .wdata_o(wdata), .wvalid_o(wvalid), .wready_i(wready),
        .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr), .arvalid_o(arvalid),
        .arready_i(arready), .rvalid_i(rvalid), .rready_o(rready));
    task automatic chk(input string name, input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic rd_exp(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        exp_q.push_back({r, 24'h00_0000, d});
        i_axi_host_model.rd(a);
    endtask
    task automatic wr_exp(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_q.push_back({r, 32'h0000_0000});
        i_axi_host_model.wr(a, d);
    endtask
    task automatic pulse(input logic [7:0] g0, input logic [2:0] jfd);
        @(posedge mclk);
        g0ev <= g0;
        {jab, fail, done} <= jfd;
        @(posedge mclk);
        g0ev <= 8'h00;
        {jab, fail, done} <= 3'b000;
    endtask
    // ************************************************************
    // monitor: each bus answer against the oldest note
    // ************************************************************
    always @(posedge mclk) begin
        if (bvalid && bready) chk("bresp", {bresp, 32'h0000_0000}, exp_q.pop_front());
        if (rvalid && rready) chk("rdata", {rresp, rdata}, exp_q.pop_front());
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        rd_exp(A_EN, RST_GROUP0_IRQ_ENABLES, RESP_OKAY);
        rd_exp(A_G1, RST_GROUP1_IRQ_FLAGS, RESP_OKAY);
        v = $random(seed);
        wr_exp(A_EN, v, RESP_OKAY);
        rd_exp(A_EN, v[7:0], RESP_OKAY);
        wr_exp(A_BAD, v, RESP_SLVERR);
        rd_exp(A_BAD, 8'h00, RESP_SLVERR);
        @(posedge mclk);
        link_up <= 1'b1;
        pulse(8'h00, 3'b111);
        rd_exp(A_G1, 8'h3d, RESP_OKAY);
        rd_exp(A_G1, 8'h00, RESP_OKAY);
        @(posedge mclk);
        link_up <= 1'b0;
        wr_exp(A_G1, 32'hffff_ffff, RESP_OKAY);
        rd_exp(A_G1, 8'h10, RESP_OKAY);
        for (int k = 0; k < 8; k++) begin
            en = 8'h01 << k;
            ds = 8'h01 << ((k + 1) % 8);
            wr_exp(A_EN, {24'h00_0000, en}, RESP_OKAY);
            pulse(ds, 3'b000);
            repeat (3) @(posedge mclk);
            chk("irq_disabled", {33'h0, irq}, 34'h0);
            pulse(en, 3'b000);
            repeat (3) @(posedge mclk);
            chk("irq_enabled", {33'h0, irq}, 34'h1);
            rd_exp(A_G0, en | ds, RESP_OKAY);
            repeat (3) @(posedge mclk);
            chk("irq_cleared", {33'h0, irq}, 34'h0);
        end
        wr_exp(A_MK, 32'hffff_ffff, RESP_OKAY);
        rd_exp(A_MK, GROUP1_IMPL_MASK, RESP_OKAY);
        pulse(8'h00, 3'b100);
        repeat (3) @(posedge mclk);
        chk("irq_group1", {33'h0, irq}, 34'h1);
        rd_exp(A_G1, 8'h08, RESP_OKAY);
        repeat (3) @(posedge mclk);
        chk("irq_group1_cleared", {33'h0, irq}, 34'h0);
        pulse(8'hff, 3'b111);
        repeat (3) @(posedge mclk);
        chk("irq_before_reset", {33'h0, irq}, 34'h1);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd_exp(A_EN, RST_GROUP0_IRQ_ENABLES, RESP_OKAY);
        rd_exp(A_G0, RST_GROUP0_IRQ_FLAGS, RESP_OKAY);
        rd_exp(A_G1, RST_GROUP1_IRQ_FLAGS, RESP_OKAY);
        chk("irq_reset", {33'h0, irq}, 34'h0);
        repeat (4) @(posedge mclk);
        give_verdict();
    end
endmodule
